// [core/lsv_pkg.sv]
// Constants, register map and decode helpers for the line-side register bank.
// Assumes a 125 MHz clock and APB register access with 32-bit data.
package lsv_pkg;

  // ----------------------------------------------------------------
  // Register map: word index, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_REV   = 8'h0D;
  localparam logic [7:0] IDX_VSTAT = 8'h0E;
  localparam logic [7:0] IDX_GAIN  = 8'h0F;
  localparam logic [7:0] IDX_CTRL  = 8'h10;
  localparam logic [7:0] IDX_ISTAT = 8'h11;
  localparam logic [7:0] IDX_IMASK = 8'h12;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned REV_INTL_BIT = 6;
  localparam int unsigned REV_REV_LSB  = 2;
  localparam int unsigned REV_RXB_BIT  = 1;
  localparam int unsigned REV_TXB_BIT  = 0;
  localparam int unsigned VS_PEND_BIT  = 2;
  localparam int unsigned VS_ACT_BIT   = 1;
  localparam int unsigned VS_FAIL_BIT  = 0;
  localparam int unsigned GN_TXM_BIT   = 7;
  localparam int unsigned GN_TXA_LSB   = 4;
  localparam int unsigned GN_RXM_BIT   = 3;
  localparam int unsigned GN_RXA_LSB   = 0;
  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam int unsigned IRQ_DONE_BIT = 0;
  localparam int unsigned IRQ_FAIL_BIT = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] GAIN_RST  = 8'h00;
  localparam logic [1:0] LEG_RST   = 2'h0;
  localparam logic [1:0] IMASK_RST = 2'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ    = 125;
  localparam int unsigned VERIFY_NS  = 2000;
  localparam int unsigned VERIFY_CYC = (VERIFY_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // Gain figures in tenths of a dB
  // ----------------------------------------------------------------
  localparam logic [7:0] LEG_TX_TENTHS = 8'h1E;
  localparam logic [7:0] LEG_RX_TENTHS = 8'h3C;

  typedef enum logic [1:0] {
    LSV_IDLE = 2'h0,
    LSV_RUN  = 2'h1,
    LSV_DONE = 2'h3
  } lsv_vstate_e;

  // Shared 0/3/6/9/12 dB step used by both transmit and receive selectors.
  function automatic logic [7:0] lsv_step_tenths(input logic [2:0] sel);
    logic [7:0] t;
    t = 8'h00;
    unique casez (sel)
      3'b000: t = 8'h00;
      3'b001: t = 8'h1E;
      3'b010: t = 8'h3C;
      3'b011: t = 8'h5A;
      3'b1??: t = 8'h78;
    endcase
    return t;
  endfunction : lsv_step_tenths

endpackage : lsv_pkg

// [core/lsv_core_if.sv]
// Carrier between the register bank and its gain decoder and checker.
// Assumes all three modules share one clock.
`timescale 1ns/1ps
interface lsv_core_if;
  logic [7:0] gain_ctrl;
  logic [1:0] legacy;
  logic [7:0] tx_atten;
  logic [7:0] rx_gain;
  logic [7:0] mon_atten;
  logic       start;
  logic       id_ok;
  logic       pending;
  logic       active;
  logic       fail;
  logic       done;

  modport dec (input gain_ctrl, legacy, output tx_atten, rx_gain, mon_atten);
  modport ver (input start, id_ok, output pending, active, fail, done);
  modport top (output gain_ctrl, legacy, start, id_ok,
               input tx_atten, rx_gain, mon_atten, pending, active, fail,
               done);
endinterface : lsv_core_if

// [core/lsv_gain_decode.sv]
// Gain decoder: turns gain control fields into registered dB figures.
// Assumes field values arrive from registers on the same clock.
`timescale 1ns/1ps
module lsv_gain_decode (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic reset_i,
  // Fields in, figures out
  lsv_core_if.dec   cif
);

  typedef struct packed {
    logic [7:0] tx;
    logic [7:0] rx;
    logic [7:0] mon;
  } lsv_dec_s;

  lsv_dec_s q;
  lsv_dec_s d;

  always_comb begin
    logic [2:0] txs;
    logic [2:0] rxs;
    txs = cif.gain_ctrl[lsv_pkg::GN_TXA_LSB +: 3];
    rxs = cif.gain_ctrl[lsv_pkg::GN_RXA_LSB +: 3];
    d.tx = lsv_pkg::lsv_step_tenths(txs);
    if (cif.legacy[lsv_pkg::REV_TXB_BIT]) begin
      d.tx = d.tx + lsv_pkg::LEG_TX_TENTHS;
    end
    d.rx = lsv_pkg::lsv_step_tenths(rxs);
    if (cif.legacy[lsv_pkg::REV_RXB_BIT]) begin
      d.rx = d.rx + lsv_pkg::LEG_RX_TENTHS;
    end
    unique casez (rxs)
      3'b000: d.mon = 8'h00;
      3'b001: d.mon = 8'h0A;
      3'b010: d.mon = 8'h16;
      3'b011: d.mon = 8'h23;
      3'b1??: d.mon = 8'h32;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign cif.tx_atten  = q.tx;
  assign cif.rx_gain   = q.rx;
  assign cif.mon_atten = q.mon;

endmodule : lsv_gain_decode

// [core/lsv_verify.sv]
// Line-side identity checker: runs once after the first enable.
// Assumes the identity level is already synchronised to the clock.
`timescale 1ns/1ps
module lsv_verify (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic reset_i,
  // Start, identity and result
  lsv_core_if.ver   cif
);

  typedef struct packed {
    lsv_pkg::lsv_vstate_e st;
    logic [7:0]           cnt;
    logic                 fail;
    logic                 done;
  } lsv_ver_s;

  lsv_ver_s q;
  lsv_ver_s d;

  always_comb begin
    d      = q;
    d.done = 1'b0;
    unique case (q.st)
      lsv_pkg::LSV_IDLE: begin
        if (cif.start) begin
          d.st  = lsv_pkg::LSV_RUN;
          d.cnt = 8'h00;
        end
      end
      lsv_pkg::LSV_RUN: begin
        d.cnt = q.cnt + 8'h01;
        if (q.cnt == 8'(lsv_pkg::VERIFY_CYC - 1)) begin
          d.st   = lsv_pkg::LSV_DONE;
          d.fail = ~cif.id_ok;
          d.done = 1'b1;
        end
      end
      lsv_pkg::LSV_DONE: begin
        d.st = lsv_pkg::LSV_DONE;
      end
      default: d.st = lsv_pkg::LSV_IDLE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      q <= '{st: lsv_pkg::LSV_IDLE, cnt: 8'h00, fail: 1'b0, done: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign cif.pending = (q.st != lsv_pkg::LSV_DONE);
  assign cif.active  = (q.st == lsv_pkg::LSV_RUN);
  assign cif.fail    = q.fail;
  assign cif.done    = q.done;

endmodule : lsv_verify

// [core/lsv_regs.sv]
// Line-side identity, verification status and gain control register bank.
// Assumes an APB master on clock_i and line-side pins from another domain.
//
// Behaviour
// - Revision bit 6 reads the line-side international capability flag.
// - Revision bits 5:2 read the four-bit line-side revision.
// - Legacy receive boost bit adds 6 dB to receive gain.
// - Legacy transmit attenuation bit adds 3 dB transmit attenuation.
// - Identity check starts by itself when the line side is enabled.
// - Pending flag reads one until the check has completed.
// - Active flag reads one only while the check runs.
// - Failed check sets result bit; registers work, data transfer stops.
// - Transmit mute bit silences the transmit signal.
// - Transmit selector gives 0, 3, 6, 9 or 12 dB attenuation.
// - Receive mute bit silences the receive signal.
// - Receive selector gives 0, 1, 2.2, 3.5 or 5 dB monitor attenuation.
`timescale 1ns/1ps
module lsv_regs (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Line-side pins
  input  wire logic        line_side_intl_flag_i,
  input  wire logic [3:0]  line_side_revision_i,
  input  wire logic        line_side_id_ok_i,
  // Signal path control
  output logic             tx_mute_o,
  output logic             rx_mute_o,
  output logic      [7:0]  tx_atten_o,
  output logic      [7:0]  rx_gain_o,
  output logic      [7:0]  mon_atten_o,
  output logic             xfer_enable_o,
  // Interrupt
  output logic             irq_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0]  sync1;
    logic [5:0]  sync2;
    logic [7:0]  gain;
    logic [1:0]  legacy;
    logic        enable;
    logic [1:0]  ist;
    logic [1:0]  imask;
    logic        ack;
    logic        err;
    logic [31:0] rdata;
    logic        tx_mute;
    logic        rx_mute;
    logic        xfer;
    logic        irq;
  } lsv_top_s;

  lsv_top_s q;
  lsv_top_s d;

  lsv_core_if cif ();

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic lsv_mapped(input logic [11:0] a);
    logic [7:0] i;
    i = a[9:2];
    return (a[1:0] == 2'h0) && (a[11:10] == 2'h0) &&
           ((i == lsv_pkg::IDX_REV)   || (i == lsv_pkg::IDX_VSTAT) ||
            (i == lsv_pkg::IDX_GAIN)  || (i == lsv_pkg::IDX_CTRL)  ||
            (i == lsv_pkg::IDX_ISTAT) || (i == lsv_pkg::IDX_IMASK));
  endfunction : lsv_mapped

  // ----------------------------------------------------------------
  // Synchronised pins
  // ----------------------------------------------------------------
  // Sync order: id_ok, revision[3:0], international flag.
  logic       pin_intl;
  logic [3:0] pin_rev;
  logic       pin_id_ok;

  assign pin_intl  = q.sync2[5];
  assign pin_rev   = q.sync2[4:1];
  assign pin_id_ok = q.sync2[0];

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  assign cif.gain_ctrl = q.gain;
  assign cif.legacy    = q.legacy;
  // The check begins once, at the first enable after reset.
  assign cif.start     = q.enable;
  assign cif.id_ok     = pin_id_ok;

  lsv_gain_decode u_dec (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .cif     (cif)
  );

  lsv_verify u_ver (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .cif     (cif)
  );

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] rd_byte;
  logic [7:0] rd_rev;
  logic [7:0] rd_vstat;

  always_comb begin
    rd_rev = 8'h00;
    rd_rev[lsv_pkg::REV_INTL_BIT]      = pin_intl;
    rd_rev[lsv_pkg::REV_REV_LSB +: 4]  = pin_rev;
    rd_rev[lsv_pkg::REV_RXB_BIT]       = q.legacy[lsv_pkg::REV_RXB_BIT];
    rd_rev[lsv_pkg::REV_TXB_BIT]       = q.legacy[lsv_pkg::REV_TXB_BIT];
    rd_vstat = 8'h00;
    rd_vstat[lsv_pkg::VS_PEND_BIT] = cif.pending;
    rd_vstat[lsv_pkg::VS_ACT_BIT]  = cif.active;
    rd_vstat[lsv_pkg::VS_FAIL_BIT] = cif.fail;
  end

  always_comb begin
    rd_byte = 8'h00;
    unique case (paddr_i[9:2])
      lsv_pkg::IDX_REV:   rd_byte = rd_rev;
      lsv_pkg::IDX_VSTAT: rd_byte = rd_vstat;
      lsv_pkg::IDX_GAIN:  rd_byte = q.gain;
      lsv_pkg::IDX_CTRL:  rd_byte = {7'h00, q.enable};
      lsv_pkg::IDX_ISTAT: rd_byte = {6'h00, q.ist};
      lsv_pkg::IDX_IMASK: rd_byte = {6'h00, q.imask};
      default:            rd_byte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Setup cycle latches read data and the error answer, so every access
  // completes in exactly one access cycle with registered data.
  logic       setup;
  logic       wr;
  logic [7:0] wb;
  logic [1:0] ev;
  logic [1:0] w1c;

  assign setup = psel_i & ~penable_i;
  assign wr    = psel_i & penable_i & pwrite_i & q.ack & ~q.err & pstrb_i[0];
  assign wb    = pwdata_i[7:0];

  always_comb begin
    ev = 2'h0;
    ev[lsv_pkg::IRQ_DONE_BIT] = cif.done;
    ev[lsv_pkg::IRQ_FAIL_BIT] = cif.done & cif.fail;
    w1c = 2'h0;
    if (wr && (paddr_i[9:2] == lsv_pkg::IDX_ISTAT)) begin
      w1c = wb[1:0];
    end
  end

  always_comb begin
    d       = q;
    d.sync1 = {line_side_intl_flag_i, line_side_revision_i,
               line_side_id_ok_i};
    d.sync2 = q.sync1;
    d.ack   = setup;
    if (setup) begin
      d.err   = ~lsv_mapped(paddr_i);
      d.rdata = pwrite_i ? 32'h0000_0000 : {24'h00_0000, rd_byte};
    end
    if (wr) begin
      unique case (paddr_i[9:2])
        lsv_pkg::IDX_REV: begin
          // Only the two legacy gain bits are writable.
          d.legacy = wb[1:0];
        end
        lsv_pkg::IDX_GAIN:  d.gain   = wb;
        lsv_pkg::IDX_CTRL:  d.enable = wb[lsv_pkg::CTRL_EN_BIT];
        lsv_pkg::IDX_IMASK: d.imask  = wb[1:0];
        default: d.gain = q.gain;
      endcase
    end
    // A new event outranks a clear in the same cycle.
    d.ist  = (q.ist & ~w1c) | ev;
    d.irq  = |(d.ist & d.imask);
    d.tx_mute  = d.gain[lsv_pkg::GN_TXM_BIT];
    d.rx_mute  = d.gain[lsv_pkg::GN_RXM_BIT];
    // Data moves only after a passed check; a failure blocks it for good.
    d.xfer = q.enable & ~cif.pending & ~cif.active & ~cif.fail;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      q        <= '0;
      q.gain   <= lsv_pkg::GAIN_RST;
      q.legacy <= lsv_pkg::LEG_RST;
      q.imask  <= lsv_pkg::IMASK_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata_o      = q.rdata;
  assign pready_o      = q.ack;
  assign pslverr_o     = q.ack & q.err;
  assign tx_mute_o     = q.tx_mute;
  assign rx_mute_o     = q.rx_mute;
  assign tx_atten_o    = cif.tx_atten;
  assign rx_gain_o     = cif.rx_gain;
  assign mon_atten_o   = cif.mon_atten;
  assign xfer_enable_o = q.xfer;
  assign irq_o         = q.irq;

endmodule : lsv_regs

// [bench/lsv_line_model.sv]
// Line-side pin model: capability flag, revision and identity answer.
// Assumes the bank synchronises these levels into its own clock.
`timescale 1ns/1ps
module lsv_line_model #(
  parameter logic       INTL = 1'b1,
  parameter logic [3:0] REV  = 4'hA
) (
  // Fault control from the bench
  input  wire logic       bad_i,
  // Line-side pins
  output logic            intl_o,
  output logic      [3:0] rev_o,
  output logic            id_ok_o
);
  assign intl_o  = INTL;
  assign rev_o   = REV;
  // A wrong part answers only when a scenario asks for it.
  assign id_ok_o = ~bad_i;
endmodule : lsv_line_model

// [bench/lsv_regs_checker.sv]
// Port-level assertions for the line-side register bank.
// Assumes zero-wait APB answers and up to two cycles of lag on path outputs.
`timescale 1ns/1ps
module lsv_regs_checker (
  input wire logic        clock_i,
  input wire logic        reset_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0]  pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        tx_mute_o,
  input wire logic        rx_mute_o,
  input wire logic [7:0]  tx_atten_o,
  input wire logic [7:0]  rx_gain_o,
  input wire logic [7:0]  mon_atten_o,
  input wire logic        xfer_enable_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  logic [8:0] age_q;
  always_ff @(posedge clock_i) begin
    if (reset_i) age_q <= 9'h000;
    else if (age_q != 9'h1FF) age_q <= age_q + 9'h001;
  end
  setup_answer_a: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no answer after setup");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  err_ready_a: assert property (
    pready_o && (paddr_i[11:10] != 2'h0 || paddr_i[1:0] != 2'h0)
    |-> pslverr_o) else $error("bad address not refused");
  rdata_upper_a: assert property (
    pready_o |-> prdata_o[31:8] == 24'h0) else $error("upper read bits set");
  mute_lag_a: assert property (
    psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0]
    && paddr_i == 12'h03C |-> ##2
    tx_mute_o == $past(pwdata_i[7], 2) && rx_mute_o == $past(pwdata_i[3], 2))
    else $error("mute outputs do not follow write");
  mon_codes_a: assert property (mon_atten_o inside
    {8'h00, 8'h0A, 8'h16, 8'h23, 8'h32}) else $error("bad monitor code");
  gain_range_a: assert property (tx_atten_o <= 8'h96
    && rx_gain_o <= 8'hB4) else $error("gain figure out of range");
  xfer_late_a: assert property ($rose(xfer_enable_o) |->
    age_q >= 9'd250) else $error("transfer enabled before check ends");
  cover property (pslverr_o);
  cover property ($rose(irq_o));
  cover property ($rose(xfer_enable_o));
endmodule : lsv_regs_checker

// [bench/lsv_regs_test.sv]
// Self-checking bench for the line-side register bank over APB.
// Assumes the pin model and checker files are compiled before this one.
`timescale 1ns/1ps
module lsv_regs_test;
  localparam logic       INTL = 1'b1;
  localparam logic [3:0] REV  = 4'hA;
  logic        clock_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [3:0]  pstrb_i = 4'hF;
  logic        bad = 1'b0;
  logic [31:0] prdata_o, rd;
  logic        pready_o, pslverr_o, tx_mute_o, rx_mute_o, er;
  logic        xfer_enable_o, irq_o, intl, id_ok;
  logic [7:0]  tx_atten_o, rx_gain_o, mon_atten_o, g;
  logic [3:0]  rev;
  logic [7:0]  corner [8] = '{8'h00, 8'h11, 8'h22, 8'h33,
                              8'h44, 8'hFF, 8'h88, 8'h77};
  int          num_errors = 0;
  int          tests_run = 0;
  lsv_line_model #(.INTL(INTL), .REV(REV)) i_lsv_line_model (
    .bad_i(bad), .intl_o(intl), .rev_o(rev), .id_ok_o(id_ok));
  lsv_regs i_lsv_regs (.clock_i, .reset_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o,
    .pslverr_o, .line_side_intl_flag_i(intl), .line_side_revision_i(rev),
    .line_side_id_ok_i(id_ok), .tx_mute_o, .rx_mute_o, .tx_atten_o,
    .rx_gain_o, .mon_atten_o, .xfer_enable_o, .irq_o);
  initial forever #4 clock_i = ~clock_i;
  function automatic logic [7:0] stp(input logic [2:0] s);
    return s[2] ? 8'h78 : {6'h0, s[1:0]} * 8'h1E;
  endfunction : stp
  function automatic logic [7:0] mon(input logic [2:0] s);
    if (s[2]) return 8'h32;
    return s[1] ? (s[0] ? 8'h23 : 8'h16) : (s[0] ? 8'h0A : 8'h00);
  endfunction : mon
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  task automatic chk(input string n, input logic [31:0] e, s);
    tests_run++;
    if (s !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, s);
      num_errors++;
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= w;
    paddr_i <= a; pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do begin @(posedge clock_i); n++; end
    while (pready_o !== 1'b1 && n < 20);
    if (pready_o !== 1'b1) begin num_errors++; end_of_test(); end
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0; penable_i <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [11:0] a, input string n,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask : rdc
  task automatic gain_chk(input logic [7:0] v, input logic [1:0] l);
    apb(1'b1, 12'h03C, {24'h0, v});
    repeat (2) @(posedge clock_i);
    chk("tx_mute", {31'h0, v[7]}, {31'h0, tx_mute_o});
    chk("rx_mute", {31'h0, v[3]}, {31'h0, rx_mute_o});
    chk("tx_att", stp(v[6:4]) + (l[0] ? 8'h1E : 8'h0),
        tx_atten_o);
    chk("rx_gain", stp(v[2:0]) + (l[1] ? 8'h3C : 8'h0),
        rx_gain_o);
    chk("mon_att", mon(v[2:0]), mon_atten_o);
    rdc(12'h03C, "gain", {24'h0, v});
  endtask : gain_chk
  task automatic reset_dut;
    reset_i <= 1'b1;
    repeat (16) @(posedge clock_i);
    reset_i <= 1'b0;
    // Pin levels need two edges to cross the synchroniser before reads.
    repeat (2) @(posedge clock_i);
  endtask : reset_dut
  task automatic wait_done;
    int n;
    n = 0;
    do begin apb(1'b0, 12'h038, 32'h0); n++; end
    while (rd[2] !== 1'b0 && n < 200);
    if (rd[2] !== 1'b0) begin num_errors++; end_of_test(); end
  endtask : wait_done
  initial begin
    g = 8'($urandom(83494));
    reset_dut();
    rdc(12'h034, "rev", {25'h0, INTL, REV, 2'b00});
    rdc(12'h038, "vstat", 32'h4);
    rdc(12'h03C, "gain_rst", 32'h0);
    apb(1'b1, 12'h034, 32'hFFFF_FFFF);
    rdc(12'h034, "rev_ro", {25'h0, INTL, REV, 2'b11});
    gain_chk(8'h00, 2'b11);
    apb(1'b1, 12'h034, 32'h0);
    for (int i = 0; i < 16; i++) begin
      g = (i < 8) ? corner[i] : 8'($urandom);
      gain_chk(g, 2'b00);
    end
    $display("gain tests done");
    apb(1'b0, 12'h800, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    pstrb_i <= 4'hE;
    apb(1'b1, 12'h03C, 32'h0000_00FF);
    pstrb_i <= 4'hF;
    rdc(12'h03C, "strobe_off", {24'h0, g});
    chk("no_err", 32'h0, {31'h0, er});
    apb(1'b1, 12'h038, 32'h7);
    rdc(12'h038, "vstat_ro", 32'h4);
    apb(1'b1, 12'h048, 32'h0);
    apb(1'b1, 12'h040, 32'h1);
    rdc(12'h038, "vstat_run", 32'h6);
    wait_done();
    chk("vstat_ok", 32'h0, rd);
    chk("xfer", 32'h1, {31'h0, xfer_enable_o});
    chk("irq_masked", 32'h0, {31'h0, irq_o});
    rdc(12'h044, "istat", 32'h1);
    apb(1'b1, 12'h048, 32'h3);
    repeat (2) @(posedge clock_i);
    chk("irq_on", 32'h1, {31'h0, irq_o});
    apb(1'b1, 12'h044, 32'h1);
    repeat (2) @(posedge clock_i);
    chk("irq_clr", 32'h0, {31'h0, irq_o});
    $display("pass check tests done");
    bad <= 1'b1;
    reset_dut();
    apb(1'b1, 12'h048, 32'h3);
    apb(1'b1, 12'h040, 32'h1);
    wait_done();
    chk("vstat_bad", 32'h1, rd);
    chk("xfer_off", 32'h0, {31'h0, xfer_enable_o});
    chk("irq_fail", 32'h1, {31'h0, irq_o});
    rdc(12'h044, "istat_f", 32'h3);
    gain_chk(8'h5A, 2'b00);
    $display("fail check tests done");
    end_of_test();
  end
endmodule : lsv_regs_test
bind lsv_regs lsv_regs_checker i_lsv_regs_checker (.clock_i, .reset_i,
  .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
  .prdata_o, .pready_o, .pslverr_o, .tx_mute_o, .rx_mute_o, .tx_atten_o,
  .rx_gain_o, .mon_atten_o, .xfer_enable_o, .irq_o);
